// file: core/tss_pkg.sv
// Constants shared by both ends of the touch-key serial command port.
// Assumes a 200 MHz system clock on each end and a serial clock made by the host.
//
// Function
// - Clock idles high; change on fall, sample rise.
// - Eight clocks per byte, both directions, MSB first.
// - Slave and master both sample the trailing (rising) edge.
// - Master holds select low for each byte.
// - Serial clock never exceeds 1.5 MHz.
// - Master waits 150 us between bytes.
// - First command byte sets the transaction mode.
// - Over 100 ms gap resets the command machine.
// - New command exchange returns the idle code.
// - Host sends null while only reading data.
// - With checksum on, act only after verification.
// - Device returns expected checksum during checksum byte.
// - Returned data is followed by its checksum.
// - Control commands take one byte, two with checksum.
// - Setup download halts sensing, applies 42 bytes together.
// - Download checksum covers the command byte too.
// - Report bytes return during host null exchanges.
package tss_pkg;
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned SCK_MAX_HZ   = 1_500_000;
    localparam int unsigned GAP_US       = 150;
    localparam int unsigned TIMEOUT_MS   = 100;
    // Half serial period rounds up so the clock never runs faster than allowed.
    localparam int unsigned SCK_HALF_CYC = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
    localparam int unsigned GAP_CYC      = (GAP_US * (CLK_HZ / 1_000_000));
    localparam int unsigned TIMEOUT_CYC  = TIMEOUT_MS * (CLK_HZ / 1_000);
    localparam logic [7:0]  IDLE_CODE    = 8'h55;
    localparam logic [7:0]  NULL_CMD     = 8'h00;
    localparam logic [7:0]  SETUPS_CMD   = 8'h01;
    localparam int unsigned SETUP_LEN    = 42;
    localparam int unsigned SETUP_BITS   = SETUP_LEN * 8;
    localparam int unsigned REP_LEN      = 2;
    localparam int unsigned REP_BITS     = REP_LEN * 8;
    localparam int unsigned REPORT_BIT   = 7;
    localparam logic [7:0]  CRC_POLY     = 8'h18;
    localparam logic [7:0]  CRC_INIT     = 8'h00;
    localparam int unsigned FIFO_DEPTH   = 8;
    localparam int unsigned FIFO_WIDTH   = 9;
    localparam int unsigned LAST_BIT     = 8;
endpackage : tss_pkg

// file: core/tss_if.sv
// Four-wire serial link between the host end and the touch-key device end.
// Assumes the host drives clock, select and data out; the device drives one data line.
`timescale 1ns/10ps
`default_nettype none
interface tss_if;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    modport dev  (input sck, input ss_n, input mosi, output miso);
    modport host (output sck, output ss_n, output mosi, input miso);
endinterface : tss_if
`default_nettype wire

// file: core/tss_dev.sv
// Device end of the serial command port, plus the bytewise checksum module.
// Assumes the host keeps the byte gap, so a byte and its answer are stable across domains.
`timescale 1ns/10ps
`default_nettype none
module tss_crc #(
    parameter logic [7:0] POLY = tss_pkg::CRC_POLY,
    parameter logic [7:0] INIT = tss_pkg::CRC_INIT
) (
    input  wire logic       i_start,
    input  wire logic [7:0] i_crc,
    input  wire logic [7:0] i_byte,
    output logic      [7:0] o_crc
);
    always_comb
    begin
        logic [7:0] c;
        c = (i_start ? INIT : i_crc) ^ i_byte;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
        end
        o_crc = c;
    end
endmodule : tss_crc

module tss_dev_end
    import tss_pkg::*;
#(
    parameter int unsigned TIMEOUT = tss_pkg::TIMEOUT_CYC
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rstn,
    tss_if.dev                                 link,
    input  wire logic                          i_crc_en,
    input  wire logic [tss_pkg::REP_BITS-1:0]  i_report,
    output logic                               o_cmd_valid,
    output logic      [7:0]                    o_cmd,
    output logic                               o_setup_apply,
    output logic      [tss_pkg::SETUP_BITS-1:0] o_setup_data,
    output logic                               o_sense_halt,
    output logic                               o_crc_err
);
    import tss_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DATA = 5'h02,
        S_CRC  = 5'h04,
        S_OUT  = 5'h08,
        S_OCRC = 5'h10
    } tss_st_t;

    typedef struct packed {
        logic [7:0] rx;
        logic [7:0] byte_w;
        logic       tgl;
    } tss_lnk_t;

    typedef struct packed {
        logic                  tgl_s1;
        logic                  tgl_s2;
        logic                  tgl_old;
        tss_st_t               st;
        logic [5:0]            cnt;
        logic [7:0]            cmd;
        logic [7:0]            crc;
        logic [7:0]            tx;
        logic [24:0]           timer;
        logic                  cmd_v;
        logic                  apply;
        logic                  halt;
        logic                  crc_err;
        logic [SETUP_BITS-1:0] setup;
    } tss_core_t;

    function automatic logic [7:0] rep_byte(input logic [REP_BITS-1:0] r, input logic [5:0] i);
        rep_byte = r[REP_BITS - 8 - 8 * i +: 8];
    endfunction : rep_byte

    // Link domain, clocked by the host's serial clock.
    tss_lnk_t   lnk_q;
    tss_lnk_t   lnk_d;
    logic [2:0] bit_cnt_q;
    logic       bit_rst_n;
    logic       miso_q;
    tss_core_t  q;
    tss_core_t  d;
    logic       crc_start;
    logic [7:0] crc_byte;
    logic [7:0] crc_nx;

    // Select high between bytes re-aligns the bit count even after a lost clock.
    assign bit_rst_n = i_rstn & ~link.ss_n;

    always_ff @(posedge link.sck or negedge bit_rst_n)
    begin
        if (!bit_rst_n)
            bit_cnt_q <= 3'h0;
        else
            bit_cnt_q <= bit_cnt_q + 3'h1;
    end

    always_comb
    begin
        lnk_d = lnk_q;
        lnk_d.rx = {lnk_q.rx[6:0], link.mosi};
        if (bit_cnt_q == 3'h7)
        begin
            lnk_d.byte_w = {lnk_q.rx[6:0], link.mosi};
            lnk_d.tgl    = ~lnk_q.tgl;
        end
    end

    always_ff @(posedge link.sck or negedge i_rstn)
    begin
        if (!i_rstn)
            lnk_q <= '0;
        else
            lnk_q <= lnk_d;
    end

    // The answer word is written by the core only after a byte ends, and the host gap
    // keeps it steady long before the next falling edge reads it.
    always_ff @(negedge link.sck or negedge i_rstn)
    begin
        if (!i_rstn)
            miso_q <= 1'b0;
        else
            miso_q <= q.tx[~bit_cnt_q];
    end
    assign link.miso = miso_q;

    assign crc_start = (q.st == S_IDLE) || ((q.st == S_OUT) && (q.cnt == 6'h00));
    assign crc_byte  = (q.st == S_OUT) ? q.tx : lnk_q.byte_w;

    tss_crc #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc (
        .i_start (crc_start),
        .i_crc   (q.crc),
        .i_byte  (crc_byte),
        .o_crc   (crc_nx)
    );

    always_comb
    begin
        logic       got;
        logic [7:0] b;
        got = q.tgl_s2 ^ q.tgl_old;
        b = lnk_q.byte_w;
        d = q;
        d.cmd_v   = 1'b0;
        d.apply   = 1'b0;
        d.crc_err = 1'b0;
        d.tgl_s1  = lnk_q.tgl;
        d.tgl_s2  = q.tgl_s1;
        d.tgl_old = q.tgl_s2;
        if (got || q.st == S_IDLE)
            d.timer = 25'h0;
        else
            d.timer = q.timer + 25'h1;
        if (q.st != S_IDLE && !got && q.timer >= 25'(TIMEOUT - 1))
        begin
            d.st   = S_IDLE;
            d.tx   = IDLE_CODE;
            d.halt = 1'b0;
        end
        else if (got)
        begin
            d.crc = crc_nx;
            d.cnt = q.cnt + 6'h1;
            unique case (q.st)
                S_IDLE:
                begin
                    d.cmd = b;
                    d.cnt = 6'h00;
                    d.tx  = IDLE_CODE;
                    if (b == SETUPS_CMD)
                    begin
                        d.st   = S_DATA;
                        d.halt = 1'b1;
                    end
                    else if (i_crc_en)
                    begin
                        d.st = S_CRC;
                        d.tx = crc_nx;
                    end
                    else if (b[REPORT_BIT])
                    begin
                        d.st = S_OUT;
                        d.tx = rep_byte(i_report, 6'h00);
                    end
                    else
                        d.cmd_v = 1'b1;
                end
                S_DATA:
                begin
                    d.setup = {q.setup[SETUP_BITS-9:0], b};
                    if (q.cnt == 6'(SETUP_LEN - 1))
                    begin
                        if (i_crc_en)
                        begin
                            d.st = S_CRC;
                            d.tx = crc_nx;
                        end
                        else
                        begin
                            d.st    = S_IDLE;
                            d.apply = 1'b1;
                            d.halt  = 1'b0;
                        end
                    end
                end
                S_CRC:
                begin
                    d.st   = S_IDLE;
                    d.tx   = IDLE_CODE;
                    d.halt = 1'b0;
                    d.cnt  = 6'h00;
                    if (b != q.crc)
                        d.crc_err = 1'b1;
                    else if (q.cmd == SETUPS_CMD)
                        d.apply = 1'b1;
                    else if (q.cmd[REPORT_BIT])
                    begin
                        d.st = S_OUT;
                        d.tx = rep_byte(i_report, 6'h00);
                    end
                    else
                        d.cmd_v = 1'b1;
                end
                S_OUT:
                begin
                    if (q.cnt == 6'(REP_LEN - 1))
                    begin
                        d.st = i_crc_en ? S_OCRC : S_IDLE;
                        d.tx = i_crc_en ? crc_nx : IDLE_CODE;
                    end
                    else
                        d.tx = rep_byte(i_report, d.cnt);
                end
                S_OCRC:
                begin
                    d.st = S_IDLE;
                    d.tx = IDLE_CODE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q    <= '0;
            q.st <= S_IDLE;
            q.tx <= IDLE_CODE;
        end
        else
            q <= d;
    end

    assign o_cmd_valid   = q.cmd_v;
    assign o_cmd         = q.cmd;
    assign o_setup_apply = q.apply;
    assign o_setup_data  = q.setup;
    assign o_sense_halt  = q.halt;
    assign o_crc_err     = q.crc_err;
endmodule : tss_dev_end
`default_nettype wire

// file: core/tss_host.sv
// Host end of the serial command port and its byte FIFO.
// Assumes a 200 MHz clock; the serial clock is divided down from it and driven out.
`timescale 1ns/10ps
`default_nettype none
module tss_fifo #(
    parameter int unsigned W = 9,
    parameter int unsigned D = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic      [W-1:0] o_out_data,
    input  wire logic         i_out_ready
);
    localparam int unsigned AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [AW:0]         cnt;
        logic                rdy;
        logic                vld;
    } tss_fifo_st_t;
    tss_fifo_st_t q;
    tss_fifo_st_t d;

    always_comb
    begin
        logic push;
        logic pop;
        push = i_in_valid & q.rdy;
        pop  = i_out_ready & q.vld;
        d = q;
        if (push)
        begin
            d.mem[q.wr] = i_in_data;
            d.wr = (q.wr == AW'(D - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop)
            d.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + 1'b1;
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        d.rdy = (d.cnt != (AW + 1)'(D));
        d.vld = (d.cnt != '0);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q     <= '0;
            q.rdy <= 1'b1;
        end
        else
            q <= d;
    end

    assign o_in_ready  = q.rdy;
    assign o_out_valid = q.vld;
    assign o_out_data  = q.mem[q.rd];
endmodule : tss_fifo

module tss_host_end
    import tss_pkg::*;
#(
    parameter int unsigned GAP = tss_pkg::GAP_CYC
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rstn,
    tss_if.host                                link,
    input  wire logic                          i_crc_en,
    input  wire logic                          i_tx_valid,
    input  wire logic [tss_pkg::FIFO_WIDTH-1:0] i_tx_data,
    output logic                               o_tx_ready,
    output logic                               o_rx_valid,
    output logic      [7:0]                    o_rx_data
);
    import tss_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_LEAD = 5'h02,
        H_LOW  = 5'h04,
        H_HIGH = 5'h08,
        H_GAP  = 5'h10
    } tss_hst_t;

    typedef struct packed {
        logic       miso_s1;
        logic       miso_s2;
        tss_hst_t   st;
        logic [6:0] div;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic [7:0] rx;
        logic [15:0] gap;
        logic [7:0] crc;
        logic       fresh;
        logic       crc_pend;
        logic       sck;
        logic       ss_n;
        logic       mosi;
        logic       rx_v;
    } tss_host_st_t;

    tss_host_st_t            q;
    tss_host_st_t            d;
    logic                    f_valid;
    logic [FIFO_WIDTH-1:0]   f_data;
    logic                    f_pop;
    logic [7:0]              crc_nx;
    logic                    half_done;

    assign half_done = (q.div == 7'(SCK_HALF_CYC - 1));
    assign f_pop     = (q.st == H_IDLE) && !q.crc_pend;

    // The FIFO holds up to 8 bytes while a byte and its gap run; the user stalls only when it is full.
    tss_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_in_valid  (i_tx_valid),
        .i_in_data   (i_tx_data),
        .o_in_ready  (o_tx_ready),
        .o_out_valid (f_valid),
        .o_out_data  (f_data),
        .i_out_ready (f_pop)
    );

    tss_crc #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc (
        .i_start (q.fresh),
        .i_crc   (q.crc),
        .i_byte  (f_data[7:0]),
        .o_crc   (crc_nx)
    );

    always_comb
    begin
        d = q;
        d.miso_s1 = link.miso;
        d.miso_s2 = q.miso_s1;
        d.rx_v    = 1'b0;
        d.div     = half_done ? 7'h00 : q.div + 7'h1;
        unique case (q.st)
            H_IDLE:
            begin
                d.div = 7'h00;
                if (q.crc_pend)
                begin
                    d.sh       = q.crc;
                    d.crc_pend = 1'b0;
                    d.fresh    = 1'b1;
                    d.st       = H_LEAD;
                    d.ss_n     = 1'b0;
                end
                else if (f_valid)
                begin
                    d.sh   = f_data[7:0];
                    d.st   = H_LEAD;
                    d.ss_n = 1'b0;
                    // A null between messages only clocks answer bytes out, so it must
                    // neither start nor join a checksum run, nor earn a checksum byte.
                    if (!(q.fresh && f_data[7:0] == NULL_CMD))
                    begin
                        d.crc   = crc_nx;
                        d.fresh = 1'b0;
                        if (f_data[LAST_BIT])
                        begin
                            d.crc_pend = i_crc_en;
                            d.fresh    = ~i_crc_en;
                        end
                    end
                end
            end
            H_LEAD:
                if (half_done)
                begin
                    d.st   = H_LOW;
                    d.sck  = 1'b0;
                    d.mosi = q.sh[7];
                    d.sh   = {q.sh[6:0], 1'b0};
                    d.bitn = 3'h0;
                end
            H_LOW:
                if (half_done)
                begin
                    d.st  = H_HIGH;
                    d.sck = 1'b1;
                    d.rx  = {q.rx[6:0], q.miso_s2};
                end
            H_HIGH:
                if (half_done)
                begin
                    if (q.bitn == 3'h7)
                    begin
                        d.st   = H_GAP;
                        d.ss_n = 1'b1;
                        d.rx_v = 1'b1;
                        d.gap  = 16'h0000;
                    end
                    else
                    begin
                        d.st   = H_LOW;
                        d.bitn = q.bitn + 3'h1;
                        d.sck  = 1'b0;
                        d.mosi = q.sh[7];
                        d.sh   = {q.sh[6:0], 1'b0};
                    end
                end
            H_GAP:
            begin
                d.gap = q.gap + 16'h0001;
                if (q.gap >= 16'(GAP - 1))
                    d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q       <= '0;
            q.st    <= H_IDLE;
            q.fresh <= 1'b1;
            q.sck   <= 1'b1;
            q.ss_n  <= 1'b1;
        end
        else
            q <= d;
    end

    assign link.sck   = q.sck;
    assign link.ss_n  = q.ss_n;
    assign link.mosi  = q.mosi;
    assign o_rx_valid = q.rx_v;
    assign o_rx_data  = q.rx;
endmodule : tss_host_end
`default_nettype wire

// file: testbench/tss_link_sva.sv
// Checker on the four link wires between the host end and the device end.
// Assumes the wires are sampled by the system clock of both ends.
`timescale 1ns/10ps
`default_nettype none
module tss_link_sva
    import tss_pkg::*;
#(
    parameter int unsigned GAP = tss_pkg::GAP_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [15:0] half_q;
    logic [15:0] gap_q;
    logic [3:0]  fall_q;
    logic [7:0]  so_q;
    logic        first_q;
    logic        sck_q;
    // Half-period and gap counts saturate so a long idle spell never wraps round into a short one.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            half_q  <= 16'hFFFF;
            gap_q   <= 16'hFFFF;
            fall_q  <= 4'h0;
            so_q    <= 8'h00;
            first_q <= 1'b1;
            sck_q   <= 1'b1;
        end
        else
        begin
            sck_q  <= sck;
            half_q <= (sck != sck_q) ? 16'h0001 : half_q + {15'h0000, half_q != 16'hFFFF};
            gap_q  <= !ss_n ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
            fall_q <= ss_n ? 4'h0 : fall_q + {3'h0, sck_q && !sck};
            if (!ss_n && !sck_q && sck)
                so_q <= {so_q[6:0], miso};
            if (ss_n && fall_q != 4'h0)
                first_q <= 1'b0;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    property p_idle_high;
        ss_n |-> sck;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("clock low while deselected");
    property p_enter;
        $fell(ss_n) |-> sck [*8];
    endproperty
    a_enter: assert property (p_enter)
        else $error("clock fell too soon after select");
    property p_mosi_hold;
        (!ss_n && !$past(ss_n) && sck && $past(sck)) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("host data moved while clock high");
    property p_miso_hold;
        (!ss_n && !$past(ss_n) && sck && $past(sck)) |-> $stable(miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold)
        else $error("device data moved while clock high");
    property p_in_frame;
        $fell(sck) |-> !ss_n;
    endproperty
    a_in_frame: assert property (p_in_frame)
        else $error("clock pulse outside select");
    property p_half;
        (sck != sck_q) |-> half_q >= SCK_HALF_CYC;
    endproperty
    a_half: assert property (p_half)
        else $error("serial clock too fast");
    property p_eight;
        $rose(ss_n) |-> fall_q == 4'h8;
    endproperty
    a_eight: assert property (p_eight)
        else $error("byte without eight clocks");
    property p_gap;
        $fell(ss_n) |-> gap_q >= GAP;
    endproperty
    a_gap: assert property (p_gap)
        else $error("byte gap too short");
    property p_idle_code;
        ($rose(ss_n) && first_q) |-> so_q == IDLE_CODE;
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("first answer not idle code");
endmodule : tss_link_sva
`default_nettype wire

// file: testbench/touch_sensor_spi_command_port_bench.sv
// Bench joining host end and device end; drives both user sides.
// Assumes short gap and timeout parameters; expectations come from bench functions.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            error_cnt++; \
            $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); \
        end \
    end
module touch_sensor_spi_command_port_bench;
    import tss_pkg::*;
    localparam int unsigned GAP = 200;
    localparam int unsigned TMO = 2000;
    logic                  i_clk = 1'b0;
    logic                  i_rstn, host_crc, dev_crc, tx_valid, tx_ready, rx_valid;
    logic                  cmd_valid, setup_apply, sense_halt, crc_err;
    logic [8:0]            tx_data;
    logic [15:0]           report;
    logic [7:0]            rx_data, cmd, c, b, crc;
    logic [SETUP_BITS-1:0] setup_data, setup_got, setup_exp;
    logic [7:0]            rxq[$];
    int                    error_cnt = 0;
    int                    samples_checked = 0;
    int                    seed = 16483;
    int                    cmd_seen, apply_seen, crcerr_seen;
    tss_if tss_if_i ();
    tss_host_end #(.GAP(GAP)) tss_host_end_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .link(tss_if_i.host), .i_crc_en(host_crc), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
    tss_dev_end #(.TIMEOUT(TMO)) tss_dev_end_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .link(tss_if_i.dev), .i_crc_en(dev_crc), .i_report(report), .o_cmd_valid(cmd_valid),
        .o_cmd(cmd), .o_setup_apply(setup_apply), .o_setup_data(setup_data),
        .o_sense_halt(sense_halt), .o_crc_err(crc_err));
    tss_link_sva #(.GAP(GAP)) tss_link_sva_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .sck(tss_if_i.sck), .ss_n(tss_if_i.ss_n), .mosi(tss_if_i.mosi), .miso(tss_if_i.miso));
    always #2.5 i_clk = ~i_clk;
    // One-cycle pulses are taken at the falling edge, clear of the launching edge.
    always @(negedge i_clk)
    begin
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        if (cmd_valid === 1'b1)
            cmd_seen++;
        if (setup_apply === 1'b1)
        begin
            apply_seen++;
            setup_got = setup_data;
        end
        if (crc_err === 1'b1)
            crcerr_seen++;
    end
    function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] d);
        logic [7:0] r;
        r = s;
        for (int i = 7; i >= 0; i--)
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return r;
    endfunction : crc8
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic hang();
        error_cnt++;
        $display("[ERR] t=%0t got %0h exp %0h", $time, 0, 1);
        wrap_up();
    endtask : hang
    task automatic start(input logic hc, input logic dc);
        @(posedge i_clk);
        #1;
        host_crc = hc;
        dev_crc = dc;
        rxq.delete();
        cmd_seen = 0;
        apply_seen = 0;
        crcerr_seen = 0;
    endtask : start
    task automatic push(input logic [8:0] w);
        logic ok;
        ok = 1'b0;
        @(posedge i_clk);
        #1;
        tx_valid = 1'b1;
        tx_data = w;
        // Ready is read one step after each edge, never in the edge's own time step.
        for (int n = 0; n < 20000 && !ok; n++)
        begin
            ok = (tx_ready === 1'b1);
            @(posedge i_clk);
            #1;
        end
        if (!ok)
            hang();
        tx_valid = 1'b0;
    endtask : push
    task automatic wait_rx(input int n);
        for (int k = 0; k < 100000 && rxq.size() < n; k++)
            @(posedge i_clk);
        if (rxq.size() < n)
            hang();
        repeat (20) @(posedge i_clk);
    endtask : wait_rx
    initial
    begin
        i_rstn = 1'b0;
        host_crc = 1'b0;
        dev_crc = 1'b0;
        tx_valid = 1'b0;
        tx_data = 9'h000;
        report = 16'h0000;
        repeat (3) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        b = 8'($random(seed));
        c = (b[6:1] == 6'h00) ? 8'h3C : {1'b0, b[6:0]};
        start(1'b0, 1'b0);
        push({1'b1, c});
        wait_rx(1);
        `CHK(rxq[0], IDLE_CODE);
        `CHK(cmd_seen, 1);
        `CHK(cmd, c);
        $display("test control done");
        start(1'b1, 1'b1);
        push({1'b1, c});
        wait_rx(2);
        `CHK(rxq[1], crc8(CRC_INIT, c));
        `CHK(cmd_seen, 1);
        $display("test control checksum done");
        start(1'b0, 1'b1);
        push({1'b0, c});
        push({1'b1, ~crc8(CRC_INIT, c)});
        wait_rx(2);
        `CHK(crcerr_seen, 1);
        `CHK(cmd_seen, 0);
        $display("test bad checksum done");
        for (int m = 0; m < 2; m++)
        begin
            report = 16'($random(seed));
            b = 8'($random(seed));
            c = {1'b1, b[6:0]};
            start(m[0], m[0]);
            // The request ends its message, so with checksum on the host appends it.
            push({1'b1, c});
            repeat (2 + m) push({1'b0, NULL_CMD});
            wait_rx(3 + 2 * m);
            `CHK(rxq[1 + m], report[15:8]);
            `CHK(rxq[2 + m], report[7:0]);
            if (m == 1)
                `CHK(rxq[4], crc8(crc8(CRC_INIT, report[15:8]), report[7:0]));
            $display("test report done");
        end
        start(1'b1, 1'b1);
        push({1'b0, SETUPS_CMD});
        crc = crc8(CRC_INIT, SETUPS_CMD);
        for (int k = 1; k <= SETUP_LEN; k++)
        begin
            b = (k == 1) ? 8'h00 : (k == SETUP_LEN) ? 8'hFF : 8'($random(seed));
            setup_exp = {setup_exp[SETUP_BITS-9:0], b};
            crc = crc8(crc, b);
            push({k == SETUP_LEN, b});
            if (k == 20)
            begin
                `CHK(sense_halt, 1'b1);
                `CHK(apply_seen, 0);
            end
        end
        wait_rx(SETUP_LEN + 2);
        `CHK(apply_seen, 1);
        `CHK(setup_got, setup_exp);
        `CHK(sense_halt, 1'b0);
        `CHK(rxq[SETUP_LEN + 1], crc);
        $display("test setup download done");
        start(1'b0, 1'b0);
        push({1'b1, SETUPS_CMD});
        wait_rx(1);
        `CHK(sense_halt, 1'b1);
        repeat (TMO + 200) @(posedge i_clk);
        `CHK(sense_halt, 1'b0);
        `CHK(apply_seen, 0);
        start(1'b0, 1'b0);
        push({1'b1, 8'h3C});
        wait_rx(1);
        `CHK(rxq[0], IDLE_CODE);
        `CHK(cmd_seen, 1);
        $display("test timeout done");
        wrap_up();
    end
endmodule : touch_sensor_spi_command_port_bench
`default_nettype wire
